// *** core/ubg_defs.svh ***
`ifndef UBG_DEFS_SVH
`define UBG_DEFS_SVH

// register byte offsets on the register bus
`define UBG_OFF_DIV_LOW 5'h00
`define UBG_OFF_DIV_HIGH 5'h04
`define UBG_OFF_FRAC 5'h08
`define UBG_OFF_SAMP 5'h0C
`define UBG_OFF_MCR 5'h10
`define UBG_OFF_STATUS 5'h14

// modem control register bit positions
`define UBG_MCR_DTR 0
`define UBG_MCR_RTS 1
`define UBG_MCR_OP1 2
`define UBG_MCR_OP2 3
`define UBG_MCR_LOOP 4
`define UBG_MCR_PRESC 7

// reset values
`define UBG_DIV_LOW_RST 8'h01
`define UBG_DIV_HIGH_RST 8'h00
`define UBG_FRAC_RST 4'h0
`define UBG_SAMP_RST 2'h0
`define UBG_MCR_RST 8'h00

// sampling rate select codes and sample counts per bit
`define UBG_SAMP_16X 2'h0
`define UBG_SAMP_8X 2'h1
`define UBG_SAMP_4X 2'h2
`define UBG_NSAMP_16X 5'h10
`define UBG_NSAMP_8X 5'h08
`define UBG_NSAMP_4X 5'h04

// timing
`define UBG_CLK_MHZ 125
`define UBG_REF_MAX_MHZ 80

`endif

// *** core/ubg_pkg.sv ***
package ubg_pkg;

	typedef enum logic [0:0] {
		UBG_BUS_IDLE = 1'b0,
		UBG_BUS_ACK = 1'b1
	} ubg_bus_state_t;

	typedef struct packed {
		ubg_bus_state_t bus_state;
		logic waitreq;
		logic [31:0] rdata;
		logic [7:0] div_low;
		logic [7:0] div_high;
		logic [3:0] frac;
		logic [1:0] samp;
		logic [7:0] modem_control_reg;
		logic cfg_load;
		logic [4:0] sync_a;
		logic [4:0] sync_b;
		logic [15:0] bit_cnt;
	} ubg_top_st_t;

	typedef struct packed {
		logic [1:0] presc_cnt;
		logic [15:0] unit_cnt;
		logic [3:0] samp_idx;
		logic sample_tick;
		logic bit_tick;
	} ubg_div_st_t;

	typedef struct packed {
		logic rx_core;
		logic cts;
		logic dsr;
		logic cd;
		logic ri;
		logic serial_out;
		logic rts;
		logic dtr;
		logic op1;
		logic op2;
		logic irq;
		logic irq_oe;
	} ubg_loop_st_t;

endpackage

// *** core/ubg_divider.sv ***
`timescale 1ns/100ps
`include "ubg_defs.svh"

module ubg_divider
	import ubg_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic srst_i,
	// configuration
	input wire logic restart_i,
	input wire logic [15:0] divisor_i,
	input wire logic [3:0] frac_i,
	input wire logic [1:0] samp_sel_i,
	input wire logic presc4_i,
	// ticks
	output logic sample_tick_o,
	output logic bit_tick_o
);

	ubg_div_st_t st_reg;
	ubg_div_st_t st_next;
	logic [4:0] nsamp;
	logic [16:0] len;
	logic step;

	always_comb begin
		st_next = st_reg;
		st_next.sample_tick = 1'b0;
		st_next.bit_tick = 1'b0;
		case (samp_sel_i)
			`UBG_SAMP_8X: nsamp = `UBG_NSAMP_8X;
			`UBG_SAMP_4X: nsamp = `UBG_NSAMP_4X;
			default: nsamp = `UBG_NSAMP_16X;
		endcase
		// fraction spread as one extra unit on the first frac samples of a bit
		len = {1'b0, divisor_i} + ((st_reg.samp_idx < frac_i) ? 17'h00001 : 17'h00000);
		step = !presc4_i || (st_reg.presc_cnt == 2'h3);
		if (srst_i || restart_i) begin
			st_next = '0;
		end else if (divisor_i != 16'h0000) begin
			st_next.presc_cnt = presc4_i ? st_reg.presc_cnt + 2'h1 : 2'h0;
			if (step) begin
				if ({1'b0, st_reg.unit_cnt} + 17'h00001 >= len) begin
					st_next.unit_cnt = 16'h0000;
					st_next.sample_tick = 1'b1;
					if ({1'b0, st_reg.samp_idx} + 5'h01 == nsamp) begin
						st_next.samp_idx = 4'h0;
						st_next.bit_tick = 1'b1;
					end else begin
						st_next.samp_idx = st_reg.samp_idx + 4'h1;
					end
				end else begin
					st_next.unit_cnt = st_reg.unit_cnt + 16'h0001;
				end
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		st_reg <= st_next;
	end

	assign sample_tick_o = st_reg.sample_tick;
	assign bit_tick_o = st_reg.bit_tick;

	// checker helpers: clocks between ticks and samples between bit ticks
	logic [19:0] h_gap;
	logic [19:0] h_len;
	logic h_valid;
	logic [4:0] h_scnt;
	logic h_bvalid;

	always_ff @(posedge clk_sys_i) begin
		if (srst_i || restart_i) begin
			h_gap <= 20'h00001;
			h_len <= 20'h00000;
			h_valid <= 1'b0;
			h_scnt <= 5'h00;
			h_bvalid <= 1'b0;
		end else begin
			h_gap <= sample_tick_o ? 20'h00001 : h_gap + 20'h00001;
			if (sample_tick_o) begin
				h_len <= presc4_i ? {1'b0, len, 2'h0} : {3'h0, len};
				h_valid <= 1'b1;
				h_scnt <= bit_tick_o ? 5'h01 : h_scnt + 5'h01;
				h_bvalid <= h_bvalid | bit_tick_o;
			end
		end
	end

	property p_tick_gap;
		@(posedge clk_sys_i) disable iff (srst_i || restart_i)
		(sample_tick_o && h_valid) |-> (h_gap == h_len);
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("sample tick spacing wrong");

	property p_bit_samples;
		@(posedge clk_sys_i) disable iff (srst_i || restart_i)
		(bit_tick_o && h_bvalid) |-> (h_scnt == nsamp);
	endproperty
	a_bit_samples: assert property (p_bit_samples) else $error("bit tick count wrong");

	property p_zero_div;
		@(posedge clk_sys_i) disable iff (srst_i)
		(divisor_i == 16'h0000) [*2] |-> !sample_tick_o;
	endproperty
	a_zero_div: assert property (p_zero_div) else $error("tick with zero divisor");

endmodule

// *** core/ubg_loopback.sv ***
`timescale 1ns/100ps
`include "ubg_defs.svh"

module ubg_loopback
	import ubg_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic srst_i,
	// control
	input wire logic [7:0] mcr_i,
	// core side
	input wire logic tx_serial_i,
	input wire logic irq_req_i,
	// synchronised pins: serial_in, cts, dsr, cd, ri
	input wire logic [4:0] pins_i,
	// registered outputs
	output ubg_loop_st_t st_o
);

	ubg_loop_st_t st_reg;
	ubg_loop_st_t st_next;

	always_comb begin
		st_next = st_reg;
		if (srst_i) begin
			st_next = '0;
			st_next.serial_out = 1'b1;
			st_next.rx_core = 1'b1;
		end else if (mcr_i[`UBG_MCR_LOOP]) begin
			st_next.rx_core = tx_serial_i;
			st_next.cts = mcr_i[`UBG_MCR_RTS];
			st_next.dsr = mcr_i[`UBG_MCR_DTR];
			st_next.cd = mcr_i[`UBG_MCR_OP2];
			st_next.ri = mcr_i[`UBG_MCR_OP1];
			st_next.serial_out = 1'b1;
			st_next.rts = 1'b0;
			st_next.dtr = 1'b0;
			st_next.op1 = 1'b0;
			st_next.op2 = 1'b0;
			st_next.irq = 1'b0;
			st_next.irq_oe = 1'b0;
		end else begin
			st_next.rx_core = pins_i[0];
			st_next.cts = pins_i[1];
			st_next.dsr = pins_i[2];
			st_next.cd = pins_i[3];
			st_next.ri = pins_i[4];
			st_next.serial_out = tx_serial_i;
			st_next.rts = mcr_i[`UBG_MCR_RTS];
			st_next.dtr = mcr_i[`UBG_MCR_DTR];
			st_next.op1 = mcr_i[`UBG_MCR_OP1];
			st_next.op2 = mcr_i[`UBG_MCR_OP2];
			st_next.irq = irq_req_i;
			st_next.irq_oe = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		st_reg <= st_next;
	end

	assign st_o = st_reg;

endmodule

// *** core/ubg_top.sv ***
// Our own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/100ps
`include "ubg_defs.svh"

// Notes on behaviour
// - integer divisor 1 to 65535 from latches
// - four-bit fraction added to the divisor
// - bit period prescale times ceiling expression
// - prescale one or four by control bit
// - one generator times transmitter and receiver
// - generator works with reference up to 80MHz
// - high byte upper half, low byte lower
// - 8x and 4x run two, four times faster
// - select code 00 means 16x sampling
// - modem control low bits drive loopback
// - loopback joins transmitter output to receiver
// - loopback feeds modem inputs from control bits
// - in loopback host bytes come back, serial out stays high
// - interrupt pins float during loopback

module ubg_top
	import ubg_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic srst_i,

	// register bus, avalon-mm slave
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,

	// uart core side
	input wire logic tx_serial_i,
	input wire logic irq_req_i,
	output logic rx_serial_o,
	output logic sample_tick_o,
	output logic bit_tick_o,
	output logic cts_o,
	output logic dsr_o,
	output logic cd_o,
	output logic ri_o,

	// serial and modem pins, active high when asserted
	input wire logic serial_in_i,
	input wire logic clear_to_send_in_i,
	input wire logic set_ready_in_i,
	input wire logic carrier_detect_in_i,
	input wire logic ring_indicate_in_i,
	output logic serial_out_o,
	output logic rts_o,
	output logic dtr_o,
	output logic user_output_one_o,
	output logic user_output_two_o,

	// interrupt pin, floated by releasing the enable
	output logic irq_o,
	output logic irq_oe_o
);

	ubg_top_st_t st_reg;
	ubg_top_st_t st_next;
	ubg_loop_st_t loop_st;
	logic [15:0] divisor;
	logic [31:0] rd_mux;
	logic bus_req;
	logic wr_ack;
	logic loop_on;

	assign divisor = {st_reg.div_high, st_reg.div_low};
	assign bus_req = avs_read_i || avs_write_i;
	// a write lands only on the edge that sees waitrequest low
	assign wr_ack = avs_write_i && (st_reg.bus_state == UBG_BUS_ACK) && avs_byteenable_i[0];
	assign loop_on = st_reg.modem_control_reg[`UBG_MCR_LOOP];

	always_comb begin
		case (avs_address_i)
			`UBG_OFF_DIV_LOW: rd_mux = {24'h000000, st_reg.div_low};
			`UBG_OFF_DIV_HIGH: rd_mux = {24'h000000, st_reg.div_high};
			`UBG_OFF_FRAC: rd_mux = {28'h0000000, st_reg.frac};
			`UBG_OFF_SAMP: rd_mux = {30'h00000000, st_reg.samp};
			`UBG_OFF_MCR: rd_mux = {24'h000000, st_reg.modem_control_reg};
			`UBG_OFF_STATUS: begin
				// status polling stands in for interrupts while looped back
				rd_mux = {8'h00, st_reg.bit_cnt, 3'h0, loop_on,
					loop_st.ri, loop_st.cd, loop_st.dsr, loop_st.cts};
			end
			default: rd_mux = 32'h00000000;
		endcase
	end

	always_comb begin
		st_next = st_reg;
		st_next.cfg_load = 1'b0;
		// first stage is read only by the second stage
		st_next.sync_a = {ring_indicate_in_i, carrier_detect_in_i, set_ready_in_i,
			clear_to_send_in_i, serial_in_i};
		st_next.sync_b = st_reg.sync_a;
		if (bit_tick_o) begin
			st_next.bit_cnt = st_reg.bit_cnt + 16'h0001;
		end
		case (st_reg.bus_state)
			UBG_BUS_IDLE: begin
				if (bus_req) begin
					st_next.bus_state = UBG_BUS_ACK;
					st_next.waitreq = 1'b0;
					st_next.rdata = avs_read_i ? rd_mux : 32'h00000000;
				end
			end
			UBG_BUS_ACK: begin
				st_next.bus_state = UBG_BUS_IDLE;
				st_next.waitreq = 1'b1;
				if (wr_ack) begin
					case (avs_address_i)
						`UBG_OFF_DIV_LOW: begin
							// writes here while the uart sleeps are the host's hazard
							st_next.div_low = avs_writedata_i[7:0];
							st_next.cfg_load = 1'b1;
						end
						`UBG_OFF_DIV_HIGH: begin
							st_next.div_high = avs_writedata_i[7:0];
							st_next.cfg_load = 1'b1;
						end
						`UBG_OFF_FRAC: begin
							// no check that the fraction stays below the rate
							st_next.frac = avs_writedata_i[3:0];
							st_next.cfg_load = 1'b1;
						end
						`UBG_OFF_SAMP: begin
							st_next.samp = avs_writedata_i[1:0];
							st_next.cfg_load = 1'b1;
						end
						`UBG_OFF_MCR: begin
							st_next.modem_control_reg = avs_writedata_i[7:0];
							st_next.cfg_load = 1'b1;
						end
						default: begin
							st_next.cfg_load = 1'b0;
						end
					endcase
				end
			end
			default: begin
				st_next.bus_state = UBG_BUS_IDLE;
				st_next.waitreq = 1'b1;
			end
		endcase
		if (srst_i) begin
			st_next = '0;
			st_next.bus_state = UBG_BUS_IDLE;
			st_next.waitreq = 1'b1;
			st_next.div_low = `UBG_DIV_LOW_RST;
			st_next.div_high = `UBG_DIV_HIGH_RST;
			st_next.frac = `UBG_FRAC_RST;
			st_next.samp = `UBG_SAMP_RST;
			st_next.modem_control_reg = `UBG_MCR_RST;
			// serial line idles high: a low reset value would fake a start bit
			st_next.sync_a = 5'h01;
			st_next.sync_b = 5'h01;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		st_reg <= st_next;
	end

	// restart the divider on any config write so a stale count never mixes rates
	ubg_divider u_div (
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.restart_i(st_reg.cfg_load),
		.divisor_i(divisor),
		.frac_i(st_reg.frac),
		.samp_sel_i(st_reg.samp),
		.presc4_i(st_reg.modem_control_reg[`UBG_MCR_PRESC]),
		.sample_tick_o(sample_tick_o),
		.bit_tick_o(bit_tick_o)
	);

	ubg_loopback u_loop (
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.mcr_i(st_reg.modem_control_reg),
		.tx_serial_i(tx_serial_i),
		.irq_req_i(irq_req_i),
		.pins_i(st_reg.sync_b),
		.st_o(loop_st)
	);

	assign avs_readdata_o = st_reg.rdata;
	assign avs_waitrequest_o = st_reg.waitreq;
	assign rx_serial_o = loop_st.rx_core;
	assign cts_o = loop_st.cts;
	assign dsr_o = loop_st.dsr;
	assign cd_o = loop_st.cd;
	assign ri_o = loop_st.ri;
	assign serial_out_o = loop_st.serial_out;
	assign rts_o = loop_st.rts;
	assign dtr_o = loop_st.dtr;
	assign user_output_one_o = loop_st.op1;
	assign user_output_two_o = loop_st.op2;
	assign irq_o = loop_st.irq;
	assign irq_oe_o = loop_st.irq_oe;

	property p_bus_answer;
		@(posedge clk_sys_i) disable iff (srst_i)
		(bus_req && avs_waitrequest_o) |=> !avs_waitrequest_o;
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("no answer one cycle after request");

	property p_bus_release;
		@(posedge clk_sys_i) disable iff (srst_i)
		!avs_waitrequest_o |=> avs_waitrequest_o;
	endproperty
	a_bus_release: assert property (p_bus_release) else $error("waitrequest low too long");

	property p_div_high;
		@(posedge clk_sys_i) disable iff (srst_i)
		(wr_ack && avs_address_i == `UBG_OFF_DIV_HIGH)
			|=> divisor[15:8] == $past(avs_writedata_i[7:0]);
	endproperty
	a_div_high: assert property (p_div_high) else $error("divisor high byte wrong");

	property p_div_low;
		@(posedge clk_sys_i) disable iff (srst_i)
		(wr_ack && avs_address_i == `UBG_OFF_DIV_LOW)
			|=> divisor[7:0] == $past(avs_writedata_i[7:0]);
	endproperty
	a_div_low: assert property (p_div_low) else $error("divisor low byte wrong");

	property p_mcr_write;
		@(posedge clk_sys_i) disable iff (srst_i)
		(wr_ack && avs_address_i == `UBG_OFF_MCR)
			|=> ##1 (serial_out_o == (loop_on || $past(tx_serial_i)))
			&& (rts_o == (!loop_on && st_reg.modem_control_reg[`UBG_MCR_RTS]));
	endproperty
	a_mcr_write: assert property (p_mcr_write) else $error("modem control not applied");

	property p_loop_idle;
		@(posedge clk_sys_i) disable iff (srst_i)
		loop_on [*2] |-> serial_out_o && !rts_o && !dtr_o
			&& !user_output_one_o && !user_output_two_o;
	endproperty
	a_loop_idle: assert property (p_loop_idle) else $error("pins active in loopback");

	property p_loop_rx;
		@(posedge clk_sys_i) disable iff (srst_i)
		loop_on [*2] |-> rx_serial_o == $past(tx_serial_i);
	endproperty
	a_loop_rx: assert property (p_loop_rx) else $error("loopback serial path broken");

	property p_loop_modem;
		@(posedge clk_sys_i) disable iff (srst_i)
		loop_on [*2] |-> cts_o == $past(st_reg.modem_control_reg[`UBG_MCR_RTS])
			&& dsr_o == $past(st_reg.modem_control_reg[`UBG_MCR_DTR])
			&& cd_o == $past(st_reg.modem_control_reg[`UBG_MCR_OP2])
			&& ri_o == $past(st_reg.modem_control_reg[`UBG_MCR_OP1]);
	endproperty
	a_loop_modem: assert property (p_loop_modem) else $error("loopback modem map wrong");

	property p_loop_irq;
		@(posedge clk_sys_i) disable iff (srst_i)
		loop_on [*2] |-> !irq_oe_o;
	endproperty
	a_loop_irq: assert property (p_loop_irq) else $error("interrupt driven in loopback");

	property p_norm_tx;
		@(posedge clk_sys_i) disable iff (srst_i)
		(!srst_i && !loop_on) ##1 !loop_on |-> serial_out_o == $past(tx_serial_i) && irq_oe_o;
	endproperty
	a_norm_tx: assert property (p_norm_tx) else $error("normal path broken");

	property p_shared_tick;
		@(posedge clk_sys_i) disable iff (srst_i)
		bit_tick_o |-> sample_tick_o;
	endproperty
	a_shared_tick: assert property (p_shared_tick) else $error("bit tick without sample");

	property p_tick_single;
		@(posedge clk_sys_i) disable iff (srst_i)
		(sample_tick_o && divisor > 16'h0001) |=> !sample_tick_o;
	endproperty
	a_tick_single: assert property (p_tick_single) else $error("sample tick too long");

	property p_reset_out;
		@(posedge clk_sys_i)
		srst_i |=> rx_serial_o && serial_out_o && avs_waitrequest_o && !irq_oe_o;
	endproperty
	a_reset_out: assert property (p_reset_out) else $error("outputs not idle after reset");

	property p_reset_sync;
		@(posedge clk_sys_i)
		srst_i ##1 !srst_i |=> rx_serial_o;
	endproperty
	a_reset_sync: assert property (p_reset_sync) else $error("false start bit after reset");

	property p_sync_chain;
		@(posedge clk_sys_i) disable iff (srst_i)
		1'b1 |=> st_reg.sync_b == $past(st_reg.sync_a);
	endproperty
	a_sync_chain: assert property (p_sync_chain) else $error("pin synchroniser broken");

	property p_norm_pins;
		@(posedge clk_sys_i) disable iff (srst_i)
		(!srst_i && !loop_on) ##1 !loop_on
			|-> {ri_o, cd_o, dsr_o, cts_o, rx_serial_o} == $past(st_reg.sync_b);
	endproperty
	a_norm_pins: assert property (p_norm_pins) else $error("pin path broken");

	property p_read_data;
		@(posedge clk_sys_i) disable iff (srst_i)
		(avs_read_i && !avs_waitrequest_o && avs_address_i == `UBG_OFF_MCR)
			|-> avs_readdata_o == {24'h000000, st_reg.modem_control_reg};
	endproperty
	a_read_data: assert property (p_read_data) else $error("register read data wrong");

	property p_read_hold;
		@(posedge clk_sys_i) disable iff (srst_i)
		!(bus_req && avs_waitrequest_o) |=> $stable(avs_readdata_o);
	endproperty
	a_read_hold: assert property (p_read_hold) else $error("read data moved without request");

	property p_refused_write;
		@(posedge clk_sys_i) disable iff (srst_i)
		(avs_write_i && !avs_waitrequest_o && !avs_byteenable_i[0])
			|=> $stable(divisor) && $stable(st_reg.frac) && $stable(st_reg.samp)
			&& $stable(st_reg.modem_control_reg);
	endproperty
	a_refused_write: assert property (p_refused_write) else $error("disabled byte write landed");

	property p_restart;
		@(posedge clk_sys_i) disable iff (srst_i)
		st_reg.cfg_load |=> !sample_tick_o && !bit_tick_o;
	endproperty
	a_restart: assert property (p_restart) else $error("tick right after restart");

	property p_bit_count;
		@(posedge clk_sys_i) disable iff (srst_i)
		1'b1 |=> st_reg.bit_cnt == $past(st_reg.bit_cnt) + {15'h0000, $past(bit_tick_o)};
	endproperty
	a_bit_count: assert property (p_bit_count) else $error("bit tick counter wrong");

endmodule

// *** verif/ubg_line_model.sv ***
`timescale 1ns/100ps

// far end of the serial and modem pins: a remote uart holding levels
// pins_o: [0] serial line, [1] clear to send, [2] set ready, [3] carrier, [4] ring
module ubg_line_model (
	// clock
	input wire logic clk_sys_i,
	// levels requested by the bench
	input wire logic [4:0] drive_i,
	// pin levels
	output logic [4:0] pins_o
);
	// starts idle high on the serial line, modem lines deasserted
	initial pins_o = 5'h01;

	// remote side changes its lines only after a clock edge, never mid-cycle
	always @(posedge clk_sys_i) begin
		pins_o <= drive_i;
	end
endmodule

// *** verif/ubg_top_tb.sv ***
`timescale 1ns/100ps
`include "ubg_defs.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
	$display("unexpected at %0t: got %0h expected %0h", $time, (g), (e)); end end

module ubg_top_tb;
	logic clk_sys_i = 1'b0;
	logic srst_i = 1'b1;
	logic [4:0] avs_address_i = 5'h00;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h00000000;
	logic [3:0] avs_byteenable_i = 4'h0;
	logic tx_serial_i = 1'b1;
	logic irq_req_i = 1'b0;
	logic [4:0] line_drive = 5'h01;
	logic [4:0] line_pins;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o, rx_serial_o, sample_tick_o, bit_tick_o;
	logic cts_o, dsr_o, cd_o, ri_o, serial_out_o, rts_o, dtr_o;
	logic user_output_one_o, user_output_two_o, irq_o, irq_oe_o;
	int num_errors = 0;
	int samples_checked = 0;
	logic [31:0] rd;
	logic [3:0] nib;
	logic [15:0] cnt0;
	int ticks;

	always #4 clk_sys_i = ~clk_sys_i;

	ubg_line_model u_ubg_line_model (.clk_sys_i(clk_sys_i), .drive_i(line_drive),
		.pins_o(line_pins));

	ubg_top u_ubg_top (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.tx_serial_i(tx_serial_i), .irq_req_i(irq_req_i), .rx_serial_o(rx_serial_o),
		.sample_tick_o(sample_tick_o), .bit_tick_o(bit_tick_o), .cts_o(cts_o),
		.dsr_o(dsr_o), .cd_o(cd_o), .ri_o(ri_o), .serial_in_i(line_pins[0]),
		.clear_to_send_in_i(line_pins[1]), .set_ready_in_i(line_pins[2]),
		.carrier_detect_in_i(line_pins[3]), .ring_indicate_in_i(line_pins[4]),
		.serial_out_o(serial_out_o), .rts_o(rts_o), .dtr_o(dtr_o),
		.user_output_one_o(user_output_one_o), .user_output_two_o(user_output_two_o),
		.irq_o(irq_o), .irq_oe_o(irq_oe_o));

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// one avalon access; the request stands until waitrequest is seen low
	task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
		input logic [3:0] be);
		int n;
		n = 0;
		@(posedge clk_sys_i);
		avs_address_i <= a;
		avs_read_i <= !wr;
		avs_write_i <= wr;
		avs_writedata_i <= {24'h000000, d};
		avs_byteenable_i <= be;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 100);
		if (n >= 100)
			`CHK(n, 0)
		rd = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask

	// program the generator, then time one steady period of the chosen tick
	task automatic cfg(input logic [7:0] dh, input logic [7:0] dl, input logic [3:0] fr,
		input logic [1:0] sp, input logic [7:0] mc, input bit use_bit, input int exp);
		int n;
		int cyc;
		bus(1'b1, `UBG_OFF_DIV_HIGH, dh, 4'hF);
		bus(1'b1, `UBG_OFF_DIV_LOW, dl, 4'hF);
		bus(1'b1, `UBG_OFF_FRAC, {4'h0, fr}, 4'hF);
		bus(1'b1, `UBG_OFF_SAMP, {6'h00, sp}, 4'hF);
		bus(1'b1, `UBG_OFF_MCR, mc, 4'hF);
		n = 0;
		// the first tick seen may still be from the old setting
		repeat (2) begin
			do begin
				@(posedge clk_sys_i);
				n++;
			end while ((use_bit ? bit_tick_o : sample_tick_o) !== 1'b1 && n < 20000);
		end
		cyc = 0;
		do begin
			@(posedge clk_sys_i);
			cyc++;
		end while ((use_bit ? bit_tick_o : sample_tick_o) !== 1'b1 && cyc < 20000);
		`CHK(cyc, exp)
	endtask

	initial begin
		#(60000 * 8);
		num_errors++;
		report_and_stop();
	end

	initial begin
		repeat (2) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			bus(1'b0, 5'(i * 4), 8'h00, 4'hF);
			`CHK(rd, (i == 0) ? 32'h00000001 : 32'h00000000)
		end
		bus(1'b0, 5'h1C, 8'h00, 4'hF);
		`CHK(rd, 32'h00000000)
		bus(1'b1, `UBG_OFF_DIV_LOW, 8'h77, 4'h0);
		bus(1'b0, `UBG_OFF_DIV_LOW, 8'h00, 4'hF);
		`CHK(rd, 32'h00000001)
		cfg(8'h00, 8'h01, 4'h0, 2'h0, 8'h00, 1'b0, 1);
		cfg(8'h00, 8'h03, 4'h0, 2'h0, 8'h00, 1'b1, 48);
		cfg(8'h00, 8'h03, 4'h0, 2'h1, 8'h00, 1'b1, 24);
		cfg(8'h00, 8'h03, 4'h0, 2'h2, 8'h00, 1'b1, 12);
		cfg(8'h00, 8'h03, 4'h0, 2'h3, 8'h00, 1'b1, 48);
		cfg(8'h00, 8'h03, 4'h0, 2'h0, 8'h80, 1'b1, 192);
		cfg(8'h00, 8'h03, 4'h2, 2'h0, 8'h00, 1'b1, 50);
		cfg(8'h00, 8'h02, 4'h3, 2'h1, 8'h00, 1'b1, 19);
		cfg(8'h01, 8'h00, 4'h0, 2'h0, 8'h00, 1'b0, 256);
		// zero divisor: generator and bit counter must stand still
		bus(1'b1, `UBG_OFF_DIV_HIGH, 8'h00, 4'hF);
		bus(1'b0, `UBG_OFF_STATUS, 8'h00, 4'hF);
		cnt0 = rd[23:8];
		ticks = 0;
		repeat (64) begin
			@(posedge clk_sys_i);
			if (sample_tick_o !== 1'b0)
				ticks++;
		end
		`CHK(ticks, 0)
		bus(1'b0, `UBG_OFF_STATUS, 8'h00, 4'hF);
		`CHK(rd[23:8], cnt0)
		// normal mode: pins pass through, irq driven
		irq_req_i <= 1'b1;
		tx_serial_i <= 1'b0;
		line_drive <= 5'h1E;
		bus(1'b1, `UBG_OFF_MCR, 8'h0A, 4'hF);
		repeat (4) @(posedge clk_sys_i);
		`CHK({serial_out_o, rx_serial_o, rts_o, dtr_o, user_output_two_o, user_output_one_o},
			6'b001010)
		`CHK({cts_o, dsr_o, cd_o, ri_o, irq_o, irq_oe_o}, 6'h3F)
		// loopback: pins driven opposite to what the core must see
		for (int i = 0; i < 4; i++) begin
			nib = 4'(i * 5);
			tx_serial_i <= nib[0];
			line_drive <= {~nib[2], ~nib[3], ~nib[0], ~nib[1], ~nib[0]};
			bus(1'b1, `UBG_OFF_MCR, {4'h1, nib}, 4'hF);
			repeat (4) @(posedge clk_sys_i);
			`CHK({serial_out_o, rts_o, dtr_o, user_output_two_o, user_output_one_o, irq_oe_o},
				6'b100000)
			`CHK({cts_o, dsr_o, cd_o, ri_o}, {nib[1], nib[0], nib[3], nib[2]})
			`CHK(rx_serial_o, nib[0])
			tx_serial_i <= ~nib[0];
			bus(1'b0, `UBG_OFF_STATUS, 8'h00, 4'hF);
			`CHK(rd[4:0], {1'b1, nib[2], nib[3], nib[0], nib[1]})
			`CHK(rx_serial_o, ~nib[0])
		end
		bus(1'b1, `UBG_OFF_MCR, 8'h00, 4'hF);
		repeat (4) @(posedge clk_sys_i);
		`CHK(irq_oe_o, 1'b1)
		report_and_stop();
	end
endmodule
